// ==== logic/lfi_fault_irq.sv ====
// Fault interrupt enables, fault options, status latches and interrupt output
//Function
//- ground short detection runs while bit set and boost active
//- string short fault suppressed by disable bit
//- write 1h disables, 3h enables field
//- read 0h disabled, 2h enabled
//- sync loss enable bits 13-12, on
//- pump fault enable bits 11-10, on
//- pump capacitor enable bits 9-8, on
//- input overcurrent enable bits 7-6, on
//- core low 5-4, input low 1-0
//- input overvoltage enable bits 3-2, on
//- overtemperature enable bits 15-14, on
//- current resistor short bits 13-12, on
//- three resistor enables 11-6, off
//- converter overcurrent bits 5-4, on
//- converter overvoltage 3-2, reserved 1-0
//- status plus clear write clears fault
//- global enable bits 7-6 same encoding
`timescale 1ns/100ps
`include "lfi_regs.svh"
module lfi_fault_irq (
	input  wire logic            ref_clk,   // Clock, 25 MHz
	input  wire logic            nrst,      // Async reset, active low
	input  wire logic            ce,        // Clock enable, freezes state when low
	input  wire lfi_pkg::lfi_req_t req,     // Register port request
	input  wire lfi_pkg::lfi_flt_t flt,     // Raw fault detector inputs
	input  wire logic            boost_act, // Boost in soft-start or normal stage
	output logic [15:0]          rdata,     // Read data, registered
	output logic                 rvalid,    // Read data valid pulse
	output logic                 gnd_det_en,// Ground short detector enable
	output logic [5:0]           str_short, // Masked string short faults
	output logic [5:0]           sup_stat,  // Supply fault status latches
	output logic [6:0]           bst_stat,  // Boost fault status latches
	output logic                 irq        // Interrupt output, active high
);
	typedef struct packed {
		logic [15:0] options;
		logic [15:0] rdata;
		logic        rvalid;
		logic        gnd_det_en;
		logic [5:0]  str_short;
		logic [5:0]  sup_stat;
		logic [6:0]  bst_stat;
		logic        irq;
	} lfi_top_t;
	lfi_top_t st, next_st;

	logic [6:0] sup_on;
	logic [6:0] bst_on;
	logic [3:0] led_on;
	logic       wr_sup;
	logic       wr_bst;
	logic       wr_led;
	logic [15:0] sup_word;
	logic [15:0] bst_word;
	logic [15:0] led_word;

	// Expands enable states to the read encoding
	function automatic logic [15:0] pack_rd(input logic [7:0] on, input int n, input int lo);
		logic [15:0] w;
		w = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			if (i < n) begin
				w[lo + 2*i +: 2] = on[i] ? `LFI_RD_ON : `LFI_RD_OFF;
			end
		end
		return w;
	endfunction

	// Write decode per register
	assign wr_sup = req.wr && req.addr == `LFI_OFF_SUPPLY;
	assign wr_bst = req.wr && req.addr == `LFI_OFF_BOOST;
	assign wr_led = req.wr && req.addr == `LFI_OFF_LED;

	// Supply fields: input low, input ov, core low, input oc, pump cap, pump, sync loss
	// Sync loss has no status latch here, only its enable field
	lfi_enable_field #(.N(`LFI_NSUPF), .RST(32'h7F)) u_sup (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.ce      (ce),
		.wr      (wr_sup),
		.wdata   (req.wdata[13:0]),
		.on      (sup_on)
	);
	// Boost fields from bit 2 up; resistor presence fields reset off
	lfi_enable_field #(.N(`LFI_NBST), .RST(32'h63)) u_bst (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.ce      (ce),
		.wr      (wr_bst),
		.wdata   (req.wdata[15:2]),
		.on      (bst_on)
	);
	// Led register fields, global at the top
	lfi_enable_field #(.N(4), .RST(32'hF)) u_led (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.ce      (ce),
		.wr      (wr_led),
		.wdata   (req.wdata[7:0]),
		.on      (led_on)
	);

	// Read words; reserved bits read zero
	assign sup_word = pack_rd({1'h0, sup_on}, `LFI_NSUPF, 0);
	assign bst_word = pack_rd({1'h0, bst_on}, `LFI_NBST, 2);
	assign led_word = pack_rd({4'h0, led_on}, 4, 0);

	// Options, status latches, read mux and interrupt
	always_comb begin
		next_st = st;
		if (ce) begin
			next_st.rvalid = 1'b0;
			// Reserved option bits held at zero, so a bad host write is harmless
			if (req.wr && req.addr == `LFI_OFF_OPTIONS) begin
				next_st.options = req.wdata & `LFI_OPT_WMASK;
			end
			next_st.gnd_det_en = st.options[`LFI_BIT_GND] & boost_act;
			next_st.str_short = flt.str & ~st.options[5:0];
			// Clear needs status and clear bit together; a new fault wins
			for (int i = 0; i < `LFI_NSUP; i++) begin
				if (wr_sup && req.wdata[2*i+1] && req.wdata[2*i]) begin
					next_st.sup_stat[i] = 1'b0;
				end
				if (flt.sup[i]) begin
					next_st.sup_stat[i] = 1'b1;
				end
			end
			for (int i = 0; i < `LFI_NBST; i++) begin
				if (wr_bst && req.wdata[2*i+3] && req.wdata[2*i+2]) begin
					next_st.bst_stat[i] = 1'b0;
				end
				if (flt.bst[i]) begin
					next_st.bst_stat[i] = 1'b1;
				end
			end
			next_st.irq = led_on[3] &&
				(|(st.sup_stat & sup_on[5:0]) || |(st.bst_stat & bst_on));
			if (req.rd) begin
				next_st.rvalid = 1'b1;
				case (req.addr)
					`LFI_OFF_OPTIONS: next_st.rdata = st.options;
					`LFI_OFF_SUPPLY:  next_st.rdata = sup_word;
					`LFI_OFF_BOOST:   next_st.rdata = bst_word;
					`LFI_OFF_LED:     next_st.rdata = led_word;
					default:          next_st.rdata = 16'h0000;
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			st.options <= `LFI_RST_OPTIONS;
		end else begin
			st <= next_st;
		end
	end

	assign rdata      = st.rdata;
	assign rvalid     = st.rvalid;
	assign gnd_det_en = st.gnd_det_en;
	assign str_short  = st.str_short;
	assign sup_stat   = st.sup_stat;
	assign bst_stat   = st.bst_stat;
	assign irq        = st.irq;

	// Disable code clears the field next cycle
	field_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[1:0] == `LFI_WR_OFF |=> !sup_on[0])
		else $error("field not disabled");
	// Neutral code leaves the field alone
	field_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_bst && req.wdata[3:2] == `LFI_RD_ON |=> $stable(bst_on[0]))
		else $error("field changed on neutral code");
	// Read code follows the field state at the read edge
	read_code_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && req.rd && req.addr == `LFI_OFF_SUPPLY |=>
		rdata[13:12] == ($past(sup_on[6]) ? `LFI_RD_ON : `LFI_RD_OFF))
		else $error("bad read encoding");
	// Detector stays off while the option bit is clear
	gnd_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && !st.options[`LFI_BIT_GND] |=> !gnd_det_en)
		else $error("ground detect while off");
	// A set disable bit hides the string fault
	short_mask_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && st.options[0] |=> !str_short[0])
		else $error("masked short reported");
	// Status latches whatever the enable says
	stat_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && flt.sup[2] |=> sup_stat[2])
		else $error("status not latched");
	// Status plus clear written together drop the latch
	stat_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_bst && req.wdata[3:2] == `LFI_WR_ON && !flt.bst[0] |=> !bst_stat[0])
		else $error("status not cleared");
	// Global field off keeps the pin low
	irq_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && !led_on[3] |=> !irq)
		else $error("irq with global off");
	// Reserved boost bits read zero
	rsv_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && req.rd && req.addr == `LFI_OFF_BOOST |=> rdata[1:0] == `LFI_RD_OFF)
		else $error("reserved bits nonzero");
	// Sync loss field turns on with the enable code
	sync_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[13:12] == `LFI_WR_ON |=> sup_on[6])
		else $error("sync loss field not enabled");
	// Sync loss field turns off with the disable code
	sync_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[13:12] == `LFI_WR_OFF |=> !sup_on[6])
		else $error("sync loss field not disabled");
	// Zero code leaves the sync loss field alone
	sync_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[13:12] == `LFI_RD_OFF |=> $stable(sup_on[6]))
		else $error("sync loss field changed");
	// Pump fault field sits at bits 11-10
	pump_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[11:10] == `LFI_WR_OFF |=> !sup_on[5])
		else $error("pump field not disabled");
	// Pump capacitor field sits at bits 9-8
	cap_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[9:8] == `LFI_WR_OFF |=> !sup_on[4])
		else $error("capacitor field not disabled");
	// Input overcurrent field sits at bits 7-6
	ioc_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[7:6] == `LFI_WR_OFF |=> !sup_on[3])
		else $error("input overcurrent field not disabled");
	// Core supply low field sits at bits 5-4
	core_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[5:4] == `LFI_WR_OFF |=> !sup_on[2])
		else $error("core low field not disabled");
	// Input overvoltage field sits at bits 3-2
	ovp_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[3:2] == `LFI_WR_OFF |=> !sup_on[1])
		else $error("input overvoltage field not disabled");
	// Overtemperature field sits at bits 15-14
	temp_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_bst && req.wdata[15:14] == `LFI_WR_ON |=> bst_on[6])
		else $error("overtemperature field not enabled");
	// Current resistor field sits at bits 13-12
	iset_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_bst && req.wdata[13:12] == `LFI_WR_OFF |=> !bst_on[5])
		else $error("current resistor field not disabled");
	// Config resistor field sits at bits 11-10
	cfg_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_bst && req.wdata[11:10] == `LFI_WR_ON |=> bst_on[4])
		else $error("config resistor field not enabled");
	// Mode resistor field sits at bits 9-8
	mode_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_bst && req.wdata[9:8] == `LFI_WR_OFF |=> !bst_on[3])
		else $error("mode resistor field not disabled");
	// Converter overcurrent field sits at bits 5-4
	bocp_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_bst && req.wdata[5:4] == `LFI_WR_OFF |=> !bst_on[1])
		else $error("converter overcurrent field not disabled");
	// Converter overvoltage field sits at bits 3-2
	bovp_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_bst && req.wdata[3:2] == `LFI_WR_ON |=> bst_on[0])
		else $error("converter overvoltage field not enabled");
	// Global field uses the same disable code
	global_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_led && req.wdata[7:6] == `LFI_WR_OFF |=> !led_on[3])
		else $error("global field not disabled");
	// Global field uses the same enable code
	global_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_led && req.wdata[7:6] == `LFI_WR_ON |=> led_on[3])
		else $error("global field not enabled");
	// Every taken read answers one cycle later
	rd_valid_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && req.rd |=> rvalid)
		else $error("read not answered");
	// Boost read code follows its top field
	rd_boost_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && req.rd && req.addr == `LFI_OFF_BOOST |=>
		rdata[15:14] == ($past(bst_on[6]) ? `LFI_RD_ON : `LFI_RD_OFF))
		else $error("bad boost read encoding");
	// Reserved supply bits read zero
	sup_rsv_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && req.rd && req.addr == `LFI_OFF_SUPPLY |=> rdata[15:14] == `LFI_RD_OFF)
		else $error("reserved supply bits nonzero");
	// Unmasked string fault passes through
	short_pass_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && !st.options[1] && flt.str[1] |=> str_short[1])
		else $error("string short lost");
	// Detector runs when the bit is set in an active stage
	gnd_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && st.options[`LFI_BIT_GND] && boost_act |=> gnd_det_en)
		else $error("ground detect not running");
	// Boost status latches too
	stat_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && flt.bst[3] |=> bst_stat[3])
		else $error("boost status not latched");
	// Supply status clear works the same way
	sup_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && wr_sup && req.wdata[1:0] == `LFI_WR_ON && !flt.sup[0] |=> !sup_stat[0])
		else $error("supply status not cleared");
	// Enabled latched fault raises the pin
	irq_raise_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && led_on[3] && st.sup_stat[0] && sup_on[0] |=> irq)
		else $error("irq missing");
	// Clock enable low freezes all state
	freeze_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!ce |=> $stable(st))
		else $error("state moved while frozen");
endmodule

// ==== inc/lfi_regs.svh ====
// Register offsets, field positions, reset values and codes of the fault enable block
`ifndef LFI_REGS_SVH
`define LFI_REGS_SVH
`define LFI_ADDR_W        8
`define LFI_OFF_OPTIONS   8'h06
`define LFI_OFF_SUPPLY    8'h08
`define LFI_OFF_BOOST     8'h0A
`define LFI_OFF_LED       8'h0C
`define LFI_RST_OPTIONS   16'h0100
`define LFI_RST_SUPPLY    16'h2AAA
`define LFI_RST_BOOST     16'hA028
`define LFI_RST_LED       16'h00AA
`define LFI_OPT_WMASK     16'h013F
`define LFI_BOOST_WMASK   16'hFFFC
`define LFI_SUPPLY_WMASK  16'h3FFF
`define LFI_LED_WMASK     16'h00FF
`define LFI_BIT_GND       8
`define LFI_WR_OFF        2'h1
`define LFI_WR_ON         2'h3
`define LFI_RD_OFF        2'h0
`define LFI_RD_ON         2'h2
`define LFI_NSUP          6
`define LFI_NSUPF         7
`define LFI_NBST          7
`define LFI_NSTR          6
`endif

// ==== inc/lfi_pkg.sv ====
// Types of the fault enable block
package lfi_pkg;
	typedef struct packed {
		logic        wr;     // Write strobe
		logic        rd;     // Read strobe
		logic [7:0]  addr;   // Register offset
		logic [15:0] wdata;  // Write data
	} lfi_req_t;
	typedef struct packed {
		logic [5:0]  sup;    // Supply fault raw inputs
		logic [6:0]  bst;    // Boost fault raw inputs
		logic [5:0]  str;    // String internal short raw inputs
		logic        gnd;    // String ground short raw input
	} lfi_flt_t;
endpackage

// ==== logic/lfi_enable_field.sv ====
// Two-bit encoded interrupt enable field bank
`timescale 1ns/100ps
`include "lfi_regs.svh"
module lfi_enable_field #(
	parameter int        N   = 6,          // Number of fields
	parameter logic [31:0] RST = 32'h0     // One bit per field, 1 means enabled at reset
) (
	input  wire logic         ref_clk,     // Clock
	input  wire logic         nrst,        // Async reset, active low
	input  wire logic         ce,          // Clock enable
	input  wire logic         wr,          // Write to this register
	input  wire logic [2*N-1:0] wdata,     // Field write codes
	output logic [N-1:0]      on           // Enable state per field
);
	typedef struct packed {
		logic [N-1:0] on;
	} lfi_fld_t;
	lfi_fld_t st, next_st;

	// Only the two documented codes act; 0h and 2h keep state
	always_comb begin
		next_st = st;
		for (int i = 0; i < N; i++) begin
			if (ce && wr && wdata[2*i +: 2] == `LFI_WR_OFF) begin
				next_st.on[i] = 1'b0;
			end else if (ce && wr && wdata[2*i +: 2] == `LFI_WR_ON) begin
				next_st.on[i] = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st.on <= RST[N-1:0];
		end else begin
			st <= next_st;
		end
	end
	assign on = st.on;
endmodule

// ==== verif/lfi_host_model.sv ====
// Host processor model that drives the register port
`timescale 1ns/100ps
`include "lfi_regs.svh"
module lfi_host_model (
	input  wire logic        ref_clk, // Clock
	input  wire logic [15:0] rdata,   // Read data from device
	input  wire logic        rvalid,  // Read valid pulse
	output lfi_pkg::lfi_req_t req     // Request to device
);
	initial req = '0;
	// Write held over one taking edge, then released
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		req <= '{1'b1, 1'b0, a, (a == `LFI_OFF_OPTIONS) ? (d & 16'hFF3F) : d};
		@(posedge ref_clk);
		req <= '0;
	endtask
	// Read; data and valid taken once the answer edge has landed
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
		@(posedge ref_clk);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge ref_clk);
		req <= '0;
		#1;
		d = rdata;
		v = rvalid;
	endtask
endmodule

// ==== verif/led_driver_fault_irq_enables_tb.sv ====
// Self-checking bench for the fault enable block
`timescale 1ns/100ps
module led_driver_fault_irq_enables_tb;
	logic ref_clk = 1'b0, nrst = 1'b0, ce = 1'b1, boost_act = 1'b0, rvalid, v, gnd_det_en, irq;
	lfi_pkg::lfi_req_t req;
	lfi_pkg::lfi_flt_t flt = '0;
	logic [15:0] rdata, got, d;
	logic [5:0]  str_short, sup_stat;
	logic [6:0]  bst_stat;
	logic [15:0] mdl [4];
	logic [7:0]  offs [4] = '{8'h06, 8'h08, 8'h0A, 8'h0C};
	logic [15:0] msk [4] = '{16'h013F, 16'h3FFF, 16'hFFFC, 16'h00FF};
	logic [31:0] seed = 32'h0000F824;
	int failures = 0, samples_checked = 0, cycles = 0, k;

	always #20 ref_clk = ~ref_clk;

	lfi_host_model HOST (.ref_clk(ref_clk), .rdata(rdata), .rvalid(rvalid), .req(req));
	lfi_fault_irq DUT (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .req(req), .flt(flt),
		.boost_act(boost_act), .rdata(rdata), .rvalid(rvalid), .gnd_det_en(gnd_det_en),
		.str_short(str_short), .sup_stat(sup_stat), .bst_stat(bst_stat), .irq(irq));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Field model: 1h turns off, 3h turns on, other codes keep
	function automatic logic [15:0] upd(logic [15:0] o, logic [15:0] w);
		for (int i = 0; i < 8; i++) begin
			if (w[2*i+:2] == 2'h1) o[2*i+:2] = 2'h0;
			else if (w[2*i+:2] == 2'h3) o[2*i+:2] = 2'h2;
		end
		return o;
	endfunction

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Reset values of all four registers
	task automatic chk_reset();
		mdl = '{16'h0100, 16'h2AAA, 16'hA028, 16'h00AA};
		for (int i = 0; i < 4; i++) begin
			HOST.rd(offs[i], got, v);
			chk(got, mdl[i]);
			chk({15'h0000, v}, 16'h0001);
		end
	endtask

	task automatic results();
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			results();
		end
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		chk_reset();
		// Random writes to every register, each read back
		for (int n = 0; n < 60; n++) begin
			@(posedge ref_clk);
			k = xs() % 4;
			d = 16'(xs()) & msk[k];
			flt.str <= 6'(xs());
			boost_act <= 1'(xs());
			mdl[k] = (k == 0) ? d : upd(mdl[k], d);
			HOST.wr(offs[k], d);
			HOST.rd(offs[k], got, v);
			chk(got, mdl[k]);
			chk({10'h000, str_short}, {10'h000, flt.str & ~mdl[0][5:0]});
			chk({15'h0000, gnd_det_en}, {15'h0000, mdl[0][8] & boost_act});
		end
		HOST.rd(8'h10, got, v);
		chk(got, 16'h0000);
		chk({15'h0000, v}, 16'h0001);
		// Disabled fault still latches but keeps the pin quiet
		HOST.wr(8'h08, 16'h0001);
		@(posedge ref_clk);
		flt.sup <= 6'h01;
		repeat (3) @(posedge ref_clk);
		#1;
		chk({15'h0000, sup_stat[0]}, 16'h0001);
		chk({15'h0000, irq}, 16'h0000);
		// Enabling the field lets the held fault reach the pin
		HOST.wr(8'h08, 16'h0003);
		repeat (3) @(posedge ref_clk);
		#1;
		chk({15'h0000, irq}, 16'h0001);
		// Global field off silences the pin
		HOST.wr(8'h0C, 16'h0040);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({15'h0000, irq}, 16'h0000);
		@(posedge ref_clk);
		flt.sup <= 6'h00;
		flt.bst <= 7'h01;
		@(posedge ref_clk);
		flt.bst <= 7'h00;
		repeat (2) @(posedge ref_clk);
		#1;
		chk({9'h000, bst_stat}, 16'h0001);
		// Status and clear bits written together drop the latch
		HOST.wr(8'h0A, 16'h000C);
		@(posedge ref_clk);
		#1;
		chk({9'h000, bst_stat}, 16'h0000);
		// Second reset in mid-run
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		chk_reset();
		results();
	end
endmodule
